/* File: core/display_keypad_scanner.sv */
// Added by the designer: the Wishbone register port and the address map.
`timescale 1ns/1ps
module display_keypad_scanner #(
  parameter int LED_HOLD = fp_scan_pkg::LED_HOLD_CYCLES,
  parameter int CLICK_HOLD = fp_scan_pkg::CLICK_CYCLES
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [fp_scan_pkg::NUM_KEYS-1:0] keypadReturnLines,
  output logic keyPullDownEn,
  output fp_scan_pkg::panel_drive_s panelDrive,
  output logic keyClick
);

  localparam int NC = fp_scan_pkg::NUM_COLUMNS;
  localparam int NK = fp_scan_pkg::NUM_KEYS;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  logic ack_r;
  logic busReq;
  logic wrLane0;
  logic wrOdd;
  logic wrEven;
  logic wrCol;
  logic wrLamp;
  logic snapHit;
  logic [2:0] snapIdx;
  logic rdReq;
  logic hitOdd;
  logic hitEven;
  logic hitCol;
  logic hitLamp;
  logic hitLive;
  logic hitStatus;

  function automatic logic adr_match(input logic [7:0] adr, input logic [7:0] ofs);
    return adr == ofs;
  endfunction

  assign hitOdd = adr_match(adr_i, fp_scan_pkg::OFS_ODD_SEG);
  assign hitEven = adr_match(adr_i, fp_scan_pkg::OFS_EVEN_SEG);
  assign hitCol = adr_match(adr_i, fp_scan_pkg::OFS_COL_SEL);
  assign hitLamp = adr_match(adr_i, fp_scan_pkg::OFS_LAMP);
  assign hitLive = adr_match(adr_i, fp_scan_pkg::OFS_KEY_LIVE);
  assign hitStatus = adr_match(adr_i, fp_scan_pkg::OFS_STATUS);

  assign busReq = cyc_i && stb_i && !ack_r;
  assign wrLane0 = busReq && we_i && sel_i[0];
  assign rdReq = busReq && !we_i;
  // One write strobe per latch, all sharing dat_i[7:0]
  assign wrOdd = wrLane0 && hitOdd;
  assign wrEven = wrLane0 && hitEven;
  assign wrCol = wrLane0 && hitCol;
  assign wrLamp = wrLane0 && hitLamp;
  assign snapHit = (adr_i >= fp_scan_pkg::OFS_KEY_SNAP) &&
                   (adr_i <= fp_scan_pkg::OFS_KEY_SNAP_END) && (adr_i[1:0] == 2'b00);
  assign snapIdx = 3'(({24'h000000, adr_i} - 32'(fp_scan_pkg::OFS_KEY_SNAP)) >> 2);
  assign ack_o = ack_r;

  // ---------------------------------------------------------------
  // Panel latches
  // ---------------------------------------------------------------
  logic [7:0] oddSeg_r;
  logic [7:0] evenSeg_r;
  logic [7:0] colSel_r;
  logic [7:0] lamp_r;

  always_ff @(posedge clock) begin
    if (srst) begin
      oddSeg_r <= fp_scan_pkg::RST_SEG;
      evenSeg_r <= fp_scan_pkg::RST_SEG;
      colSel_r <= fp_scan_pkg::RST_COL;
      lamp_r <= fp_scan_pkg::RST_LAMP;
    end else begin
      if (wrOdd) begin
        oddSeg_r <= dat_i[7:0];
      end
      if (wrEven) begin
        evenSeg_r <= dat_i[7:0];
      end
      if (wrCol) begin
        colSel_r <= dat_i[7:0];
      end
      if (wrLamp) begin
        lamp_r <= dat_i[7:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // One-shots: LED drive guard and key click
  // ---------------------------------------------------------------
  logic ledDriveOn;
  logic clickFire;
  logic msbNew;
  logic msbOld;

  retrig_one_shot #(
    .HOLD_CYCLES(LED_HOLD)
  ) led_drive_one_shot (
    .clock(clock),
    .srst(srst),
    .trigger(wrCol),
    .active(ledDriveOn)
  );

  assign msbNew = dat_i[fp_scan_pkg::CLICK_BIT];
  assign msbOld = colSel_r[fp_scan_pkg::CLICK_BIT];
  assign clickFire = wrCol && msbNew && !msbOld;

  retrig_one_shot #(
    .HOLD_CYCLES(CLICK_HOLD)
  ) click_one_shot (
    .clock(clock),
    .srst(srst),
    .trigger(clickFire),
    .active(keyClick)
  );

  // ---------------------------------------------------------------
  // Panel outputs
  // ---------------------------------------------------------------
  localparam fp_scan_pkg::panel_drive_s DRIVE_DARK = '{
    scanColumnLines: '0,
    oddSegN: fp_scan_pkg::RST_SEG,
    evenSegN: fp_scan_pkg::RST_SEG,
    lampN: fp_scan_pkg::RST_LAMP
  };

  fp_scan_pkg::panel_drive_s drive_nxt;
  fp_scan_pkg::panel_drive_s drive_r;

  // Without the guard every column, segment and lamp is forced dark
  assign drive_nxt.scanColumnLines = ledDriveOn ? colSel_r[NC-1:0] : '0;
  assign drive_nxt.oddSegN = ledDriveOn ? oddSeg_r : DRIVE_DARK.oddSegN;
  assign drive_nxt.evenSegN = ledDriveOn ? evenSeg_r : DRIVE_DARK.evenSegN;
  assign drive_nxt.lampN = ledDriveOn ? lamp_r : DRIVE_DARK.lampN;

  always_ff @(posedge clock) begin
    if (srst) begin
      drive_r <= DRIVE_DARK;
    end else begin
      drive_r <= drive_nxt;
    end
  end

  assign panelDrive = drive_r;
  assign keyPullDownEn = 1'b1;

  // ---------------------------------------------------------------
  // Key capture when exactly one column is enabled
  // ---------------------------------------------------------------
  logic [NK-1:0] keySnap_r [NC];
  logic singleCol;
  logic [2:0] colIdx;

  function automatic logic [2:0] one_hot_index(input logic [NC-1:0] v);
    logic [2:0] idx;
    idx = '0;
    for (int i = 0; i < NC; i++) begin
      if (v[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  assign singleCol = drive_r.scanColumnLines != '0 &&
                     $onehot(drive_r.scanColumnLines);
  assign colIdx = one_hot_index(drive_r.scanColumnLines);

  always_ff @(posedge clock) begin
    if (srst) begin
      for (int i = 0; i < NC; i++) begin
        keySnap_r[i] <= '0;
      end
    end else if (singleCol) begin
      keySnap_r[colIdx] <= keypadReturnLines;
    end
  end

  // ---------------------------------------------------------------
  // Read path and ack
  // ---------------------------------------------------------------
  logic [7:0] rdByte;
  logic [7:0] keyLive;
  logic [7:0] statusByte;
  logic [7:0] snapByte;

  assign keyLive = 8'(keypadReturnLines);
  assign statusByte = (8'(keyClick) << fp_scan_pkg::STAT_CLICK_BIT) |
                      (8'(ledDriveOn) << fp_scan_pkg::STAT_DRIVE_BIT);
  assign snapByte = 8'(keySnap_r[snapIdx]);

  assign rdByte =
    hitOdd ? oddSeg_r :
    hitEven ? evenSeg_r :
    hitCol ? colSel_r :
    hitLamp ? lamp_r :
    hitLive ? keyLive :
    hitStatus ? statusByte :
    snapHit ? snapByte : 8'h00;

  always_ff @(posedge clock) begin
    if (srst) begin
      ack_r <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_r <= busReq;
      if (rdReq) begin
        dat_o <= {24'h000000, rdByte};
      end
    end
  end

endmodule // display_keypad_scanner

/* File: core/fp_scan_pkg.sv */
// What this block does
// - Four latches serve the panel: odd, even, column select, lamps.
// - Each of seven columns enables two digits, eight lamps, six keys.
// - Segment and lamp bits are active low: 0 lights, 1 darkens.
// - Key return inputs use pull-downs, reading low after release.
// - 10 ms retriggerable one-shot on column writes gates LED drive.
// - Column latch MSB going high fires a key-click one-shot.
// - A key return reads high when pressed in its enabled column.
// - Each latch captures the data bus on its own write strobe.
package fp_scan_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_ODD_SEG = 8'h00;
  localparam logic [7:0] OFS_EVEN_SEG = 8'h04;
  localparam logic [7:0] OFS_COL_SEL = 8'h08;
  localparam logic [7:0] OFS_LAMP = 8'h0c;
  localparam logic [7:0] OFS_KEY_LIVE = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_KEY_SNAP = 8'h20;
  localparam logic [7:0] OFS_KEY_SNAP_END = 8'h38;

  // ---------------------------------------------------------------
  // Field layout and reset values
  // ---------------------------------------------------------------
  localparam int NUM_COLUMNS = 7;
  localparam int NUM_KEYS = 6;
  localparam int CLICK_BIT = 7;
  localparam int STAT_DRIVE_BIT = 0;
  localparam int STAT_CLICK_BIT = 1;
  localparam logic [7:0] RST_SEG = 8'hff;
  localparam logic [7:0] RST_LAMP = 8'hff;
  localparam logic [7:0] RST_COL = 8'h00;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLOCK_KHZ = 50000;
  localparam int LED_HOLD_MS = 10;
  localparam int LED_HOLD_CYCLES = LED_HOLD_MS * CLOCK_KHZ;
  localparam int CLICK_US = 1000;
  localparam int CLICK_CYCLES = (CLICK_US * CLOCK_KHZ) / 1000;

  // ---------------------------------------------------------------
  // Carrier
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [NUM_COLUMNS-1:0] scanColumnLines;
    logic [7:0] oddSegN;
    logic [7:0] evenSegN;
    logic [7:0] lampN;
  } panel_drive_s;

endpackage

/* File: core/retrig_one_shot.sv */
`timescale 1ns/1ps
module retrig_one_shot #(
  parameter int HOLD_CYCLES = 16
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic trigger,
  output logic active
);

  localparam int CW = $clog2(HOLD_CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(HOLD_CYCLES);

  logic [CW-1:0] count_r;
  logic [CW-1:0] count_nxt;

  // ---------------------------------------------------------------
  // Reload on every trigger, else count down
  // ---------------------------------------------------------------
  assign count_nxt = trigger ? LOAD : (count_r != '0) ? count_r - 1'b1 : count_r;
  assign active = (count_r != '0);

  always_ff @(posedge clock) begin
    if (srst) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

endmodule // retrig_one_shot

/* File: tb/display_keypad_scanner_props.sv */
`timescale 1ns/1ps
module display_keypad_scanner_props #(
  parameter int LED_HOLD = 50,
  parameter int CLICK_HOLD = 20
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic [fp_scan_pkg::NUM_KEYS-1:0] keypadReturnLines,
  input wire logic keyPullDownEn,
  input wire fp_scan_pkg::panel_drive_s panelDrive,
  input wire logic keyClick
);
  logic [31:0] sinceCol_r;
  logic colTaken;
  logic unmapped;
  assign colTaken = cyc_i && stb_i && we_i && !ack_o && sel_i[0] && adr_i == 8'h08;
  assign unmapped = adr_i > 8'h38 || adr_i == 8'h18 || adr_i == 8'h1c;
  always_ff @(posedge clock) begin
    if (srst) sinceCol_r <= 32'(LED_HOLD + 8);
    else if (colTaken) sinceCol_r <= '0;
    else if (sinceCol_r < 32'(LED_HOLD + 8)) sinceCol_r <= sinceCol_r + 32'h1;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  // ---------------------
  // Checks
  // ---------------------
  a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack held");
  a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("stray ack");
  a_req_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
  a_pull_down: assert property (keyPullDownEn) else $error("pull-downs off");
  a_reset_dark: assert property ($past(srst) |-> panelDrive.scanColumnLines == 7'h0
    && panelDrive.lampN == 8'hff && !keyClick) else $error("reset state");
  a_guard_dark: assert property (sinceCol_r >= 32'(LED_HOLD + 6) |->
    panelDrive.scanColumnLines == 7'h0 && panelDrive.oddSegN == 8'hff) else $error("guard");
  a_click_cause: assert property ($rose(keyClick) |-> sinceCol_r < 32'h4)
    else $error("stray click");
  a_unmapped_zero: assert property (ack_o && $past(!we_i && unmapped) |-> dat_o == 32'h0)
    else $error("unmapped data");
  c_col: cover property (colTaken);
  c_click: cover property ($rose(keyClick));
  c_guard: cover property (sinceCol_r == 32'(LED_HOLD + 6));
endmodule // display_keypad_scanner_props
bind display_keypad_scanner display_keypad_scanner_props #(.LED_HOLD(LED_HOLD),
  .CLICK_HOLD(CLICK_HOLD)) chk (.clock(clock), .srst(srst), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .keypadReturnLines(keypadReturnLines), .keyPullDownEn(keyPullDownEn),
  .panelDrive(panelDrive), .keyClick(keyClick));

/* File: tb/front_panel_model.sv */
`timescale 1ns/1ps
module front_panel_model (
  input wire logic [6:0] columns,
  input wire logic [6:0][5:0] pressed,
  input wire logic pullDownEn,
  output logic [5:0] returns
);
  // ---------------------
  // Key matrix
  // ---------------------
  always_comb begin
    returns = '0;
    for (int c = 0; c < 7; c++) begin
      if (columns[c]) returns |= pressed[c];
    end
    if (!pullDownEn) returns = ~returns;
  end
endmodule // front_panel_model

/* File: tb/test_display_keypad_scanner.sv */
`timescale 1ns/1ps
module test_display_keypad_scanner;
  localparam int LED_HOLD = 50;
  localparam int CLICK_HOLD = 20;
  logic clock = 0;
  logic srst = 1;
  logic cyc_i = 0, stb_i = 0, we_i = 0;
  logic [7:0] adr_i = 8'h0;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o, rd;
  logic ack_o, keyPullDownEn, keyClick;
  logic [5:0] keyReturns;
  logic [7:0] seg, lamp;
  int col;
  logic [6:0][5:0] pressed = '0;
  fp_scan_pkg::panel_drive_s panelDrive;
  int errors = 0;
  int tests_run = 0;
  display_keypad_scanner #(.LED_HOLD(LED_HOLD), .CLICK_HOLD(CLICK_HOLD)) dut (.clock(clock),
    .srst(srst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .keypadReturnLines(keyReturns),
    .keyPullDownEn(keyPullDownEn), .panelDrive(panelDrive), .keyClick(keyClick));
  front_panel_model pnl (.columns(panelDrive.scanColumnLines), .pressed(pressed),
    .pullDownEn(keyPullDownEn), .returns(keyReturns));
  // ---------------------
  // Tasks
  // ---------------------
  task automatic results();
    $display("Checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [31:0] keys_expect(int c);
    return 32'(pressed[c]);
  endfunction
  function automatic logic [31:0] status_expect(logic click, logic drive);
    return (32'(click) << fp_scan_pkg::STAT_CLICK_BIT) |
      (32'(drive) << fp_scan_pkg::STAT_DRIVE_BIT);
  endfunction
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d, logic [3:0] s = 4'h1);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    @(posedge clock);
    while (ack_o !== 1'b1 && n < 20) begin
      @(posedge clock);
      n++;
    end
    if (ack_o !== 1'b1) begin
      errors++;
      results();
    end
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clock);
  endtask
  initial begin
    forever #10 clock = ~clock;
  end
  initial begin
    void'($urandom(6952));
    for (int c = 1; c < 7; c++) pressed[c] <= 6'($urandom);
    pressed[0] <= 6'h3f;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    bus(1'b0, 8'h0c, 32'h0);
    check("lamp reset", 32'hff, rd);
    bus(1'b1, 8'h00, 32'h5a);
    check("unguarded seg", 32'hff, 32'(panelDrive.oddSegN));
    for (int p = 0; p < 8; p++) begin
      col = p % 7;
      seg = 8'($urandom);
      lamp = 8'($urandom);
      bus(1'b1, 8'h08, 32'h0);
      check("cols off", 32'h0, 32'(panelDrive.scanColumnLines));
      bus(1'b1, 8'h00, {24'h0, seg});
      bus(1'b1, 8'h04, (p == 7) ? 32'hff : {24'h0, ~seg});
      bus(1'b1, 8'h0c, {24'h0, lamp});
      bus(1'b1, 8'h08, 32'h1 << col);
      check("cols", 32'h1 << col, 32'(panelDrive.scanColumnLines));
      check("odd seg", {24'h0, seg}, 32'(panelDrive.oddSegN));
      check("even seg", (p == 7) ? 32'hff : {24'h0, ~seg}, 32'(panelDrive.evenSegN));
      check("lamps", {24'h0, lamp}, 32'(panelDrive.lampN));
      bus(1'b0, 8'h10, 32'h0);
      check("live keys", keys_expect(col), rd);
    end
    for (int k = 0; k < 7; k++) begin
      bus(1'b0, 8'(8'h20 + 4 * k), 32'h0);
      check("key snap", keys_expect(k), rd);
    end
    pressed <= '0;
    bus(1'b1, 8'h08, 32'h1);
    bus(1'b0, 8'h10, 32'h0);
    check("released", 32'h0, rd);
    bus(1'b1, 8'h08, 32'h81);
    check("click on", 32'h1, 32'(keyClick));
    bus(1'b0, 8'h14, 32'h0);
    check("status", status_expect(1'b1, 1'b1), rd);
    repeat (CLICK_HOLD + 4) @(posedge clock);
    bus(1'b1, 8'h08, 32'h81);
    check("no reclick", 32'h0, 32'(keyClick));
    bus(1'b1, 8'h0c, 32'h0, 4'he);
    bus(1'b0, 8'h0c, 32'h0);
    check("sel ignored", {24'h0, lamp}, rd);
    bus(1'b0, 8'h18, 32'h0);
    check("unmapped", 32'h0, rd);
    repeat (LED_HOLD + 10) @(posedge clock);
    check("guard cols", 32'h0, 32'(panelDrive.scanColumnLines));
    check("guard lamps", 32'hff, 32'(panelDrive.lampN));
    bus(1'b0, 8'h14, 32'h0);
    check("guard status", status_expect(1'b0, 1'b0), rd);
    bus(1'b1, 8'h0c, 32'h5a);
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    bus(1'b0, 8'h0c, 32'h0);
    check("lamp mid reset", 32'hff, rd);
    results();
  end
endmodule // test_display_keypad_scanner
